// File: dv/test_twu_timer_watchdog.sv
// Self-checking bench for the timer/watchdog unit
`timescale 1ns/1ns
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin fails++; \
  $display("ERROR t=%0t got %h exp %h", $time, g, e); end end
module test_twu_timer_watchdog;
  import twu_pkg::*;
  logic sys_clk = 0, rst_b = 0, fsel = 1, wr = 0, ev, go = 0;
  logic [7:0] ctrl = 8'h00, wdat = 8'h00;
  logic [1:0] mode = 2'h0;
  twu_preset_t preset = '0;
  logic oe, irq_a, irq_b, crst, wd, wave, w0;
  logic lvl = 1, lbit = 1;
  logic [7:0] ivr = 8'h04;
  logic [15:0] cnt, c0;
  int fails = 0, num_checks = 0, edges = 0, k, p, r;
  twu_timer_watchdog u_twu_timer_watchdog (.sys_clk(sys_clk),
    .rst_b(rst_b), .timer_control_reg(ctrl), .in_mode(mode),
    .output_level_bit(lbit), .timer_function_select(fsel),
    .interrupt_vector_reg(ivr), .preset(preset), .low_byte_wr(wr),
    .counter_low_byte_reg(wdat), .timer_event_input(ev),
    .timer_wave_output(wave), .timer_wave_oe(oe),
    .prioritized_irq_channel(irq_a), .top_level_irq(irq_b),
    .internal_reset(crst), .watchdog_active(wd), .count_value(cnt));
  twu_event_src u_twu_event_src (.sys_clk(sys_clk), .go(go), .lvl(lvl),
    .ev(ev));
  initial forever #10 sys_clk = !sys_clk;
  always @(negedge ev) edges++;
  task automatic tick(int n);
    repeat (n) @(posedge sys_clk);
    #2;
  endtask
  task automatic wait_irq();
    k = 0;
    while (irq_a !== 1'b1 && irq_b !== 1'b1 && k < 40) begin
      tick(1);
      k++;
    end
  endtask
  function automatic logic [15:0] after(logic [15:0] c, int d);
    return c - 16'(d);
  endfunction
  task automatic final_report();
    $display("checks %0d fails %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    void'($urandom(32'h8707));
    tick(8);
    `CHK(cnt, 16'hFFFF)
    rst_b = 1;
    p = $urandom_range(3);
    preset = {8'(p), 16'h0040};
    ctrl = 8'h81;
    // First pass drains the reset prescaler value
    tick(1040);
    c0 = cnt;
    k = $urandom_range(9, 3);
    tick(4 * (p + 1) * k);
    `CHK(cnt, after(c0, k))
    `CHK(oe, 1'b1)
    preset.prescale = 8'h00;
    tick(24);
    ctrl = 8'h88;
    mode = TWU_IN_EVENT;
    tick(10);
    c0 = cnt;
    edges = 0;
    go = 1;
    tick(400);
    go = 0;
    tick(10);
    `CHK(cnt, after(c0, edges))
    `CHK(oe, 1'b0)
    mode = TWU_IN_GATE;
    lvl = 0;
    tick(4);
    c0 = cnt;
    tick(40);
    `CHK(cnt, c0)
    lvl = 1;
    tick(2);
    c0 = cnt;
    tick(40);
    `CHK(cnt, after(c0, 10))
    mode = TWU_IN_RETRIG;
    preset.reload = 16'h0300;
    lvl = 0;
    tick(2);
    `CHK(cnt, 16'h0300)
    mode = TWU_IN_TRIG;
    lvl = 1;
    tick(20);
    lvl = 0;
    tick(2);
    `CHK(cnt < 16'h0300, 1'b1)
    ctrl = 8'h08;
    tick(2);
    c0 = cnt;
    tick(20);
    `CHK(cnt, c0)
    ctrl = 8'h88;
    mode = TWU_IN_RETRIG;
    preset.reload = 16'h0003;
    lvl = 1;
    tick(20);
    lvl = 0;
    tick(2);
    `CHK(cnt, 16'h0003)
    ctrl = 8'h80;
    ivr = 8'h02;
    wait_irq();
    w0 = wave;
    tick(1);
    wait_irq();
    `CHK(wave, !w0)
    `CHK(cnt, 16'h0003)
    `CHK(irq_a, 1'b0)
    `CHK(irq_b, 1'b1)
    lbit = 1'($urandom_range(1));
    ivr = 8'h04;
    ctrl = 8'h84;
    tick(1);
    wait_irq();
    `CHK(wave, lbit)
    `CHK(irq_a, 1'b1)
    `CHK(irq_b, 1'b0)
    mode = TWU_IN_TRIG;
    ctrl = 8'h88;
    tick(20);
    `CHK(cnt, 16'h0000)
    preset.reload = 16'h0050;
    lvl = 1;
    tick(20);
    lvl = 0;
    tick(2);
    `CHK(cnt, 16'h0050)
    lvl = 1;
    // presets set before the watchdog switch
    r = 100 + $urandom_range(50);
    preset.reload = 16'(r);
    fsel = 0;
    tick(1);
    fsel = 1;
    tick(2);
    `CHK(wd, 1'b1)
    wr = 1;
    wdat = TWU_KEY_FIRST;
    tick(1);
    wdat = TWU_KEY_SECOND;
    tick(1);
    wr = 0;
    tick(1);
    `CHK(cnt <= 16'(r) && cnt + 16'h1 >= 16'(r), 1'b1)
    k = 0;
    while (crst !== 1'b1 && k < 4 * 160) begin
      tick(1);
      k++;
    end
    `CHK(crst, 1'b1)
    `CHK(k >= 4 * (r - 2), 1'b1)
    `CHK(wd, 1'b1)
    rst_b = 0;
    tick(2);
    rst_b = 1;
    tick(1);
    `CHK(wd, 1'b0)
    final_report();
  end
endmodule

// File: dv/twu_event_src.sv
// External event source on the timer input pin
`timescale 1ns/1ns
module twu_event_src (
  input wire logic sys_clk,
  input wire logic go,
  input wire logic lvl,
  output logic ev
);
  logic [4:0] n = 5'h0;
  initial ev = 1'b1;
  always @(posedge sys_clk) begin
    n <= (n == 5'h13) ? 5'h0 : n + 5'h1;
    // Stopped source follows the level the bench asks for
    if (!go)
      ev <= #2 lvl;
    else if (n == 5'h13)
      ev <= #2 !ev;
  end
endmodule

// File: dv/twu_props.sv
// Checker for the timer/watchdog unit
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
module twu_props (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] timer_control_reg,
  input wire logic timer_function_select,
  input wire logic [7:0] interrupt_vector_reg,
  input wire twu_pkg::twu_preset_t preset,
  input wire logic low_byte_wr,
  input wire logic [7:0] counter_low_byte_reg,
  input wire logic timer_wave_oe,
  input wire logic prioritized_irq_channel,
  input wire logic top_level_irq,
  input wire logic internal_reset,
  input wire logic watchdog_active,
  input wire logic [15:0] count_value
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence key_seq;
    low_byte_wr && counter_low_byte_reg == 8'hAA ##1
    low_byte_wr && counter_low_byte_reg == 8'h55;
  endsequence
  a_wdog_enter: assert property (!timer_function_select |=>
    watchdog_active) else $error("watchdog not entered");
  a_wdog_sticky: assert property (watchdog_active |=>
    watchdog_active) else $error("watchdog left");
  a_reset_wdog_only: assert property (internal_reset |->
    watchdog_active) else $error("chip reset in timer mode");
  a_wdog_no_irq: assert property (watchdog_active [*2] |=>
    !prioritized_irq_channel && !top_level_irq) else $error("irq in wdog");
  a_oe_off: assert property (!timer_control_reg[0] |=>
    !timer_wave_oe) else $error("pin driven while disabled");
  a_key_reload: assert property ((watchdog_active ##0 key_seq) |->
    ##[1:2] count_value == preset.reload) else $error("no key reload");
  a_stop_hold: assert property (!timer_control_reg[7] &&
    timer_function_select && !watchdog_active |=> $stable(count_value))
    else $error("stopped timer moved");
  a_irq_route: assert property (prioritized_irq_channel |->
    !$past(interrupt_vector_reg[1])) else $error("irq on wrong channel");
  a_top_route: assert property (top_level_irq |->
    !$past(interrupt_vector_reg[2])) else $error("top irq on wrong channel");
endmodule
bind twu_timer_watchdog twu_props u_props (.*);

// File: hw/twu_pkg.sv
// Constants and carrier types for the timer/watchdog unit
package twu_pkg;
  localparam int unsigned TWU_CNT_W = 16;
  localparam int unsigned TWU_PRE_W = 8;
  localparam logic [1:0] TWU_DIV_LAST = 2'h3;
  localparam logic [7:0] TWU_KEY_FIRST = 8'hAA;
  localparam logic [7:0] TWU_KEY_SECOND = 8'h55;
  localparam logic [7:0] TWU_CTRL_RESET = 8'h12;
  localparam int unsigned TWU_CTRL_OUTPUT_PIN_ENABLE_BIT = 0;
  localparam int unsigned TWU_CTRL_OUTPUT_MODE_SELECT_BIT = 2;
  localparam int unsigned TWU_CTRL_INPUT_PIN_ENABLE_BIT = 3;
  localparam int unsigned TWU_CTRL_START_STOP_BIT_BIT = 7;
  localparam int unsigned TWU_IVR_CHAN_BIT = 1;
  localparam int unsigned TWU_IVR_TOP_BIT = 2;
  localparam int unsigned TWU_CLK_MHZ = 50;
  localparam int unsigned TWU_EDGE_GAP_NS = 333;
  localparam int unsigned TWU_EDGE_GAP_CYC =
    (TWU_EDGE_GAP_NS * TWU_CLK_MHZ + 999) / 1000;

  typedef enum logic [1:0] {
    TWU_IN_EVENT = 2'h0,
    TWU_IN_GATE = 2'h1,
    TWU_IN_TRIG = 2'h3,
    TWU_IN_RETRIG = 2'h2
  } twu_in_mode_t;

  typedef struct packed {
    logic [TWU_PRE_W-1:0] prescale;
    logic [TWU_CNT_W-1:0] reload;
  } twu_preset_t;

  typedef struct packed {
    logic [1:0] div;
    logic [TWU_PRE_W-1:0] pre;
    logic [TWU_CNT_W-1:0] cnt;
    logic wdog;
    logic key_armed;
    logic in_prev;
    logic wave;
    logic wave_oe;
    logic irq_chan;
    logic irq_top;
    logic wd_reset;
    logic at_end;
  } twu_state_t;
endpackage

// File: hw/twu_timer_watchdog.sv
// Timer/watchdog: 16-bit down-counter, 8-bit prescaler, watchdog mode
`timescale 1ns/1ns
////////////////////////////////////////////////////////////////////////////
// Summary of operation
// (RL1) 16-bit down-counter behind 8-bit prescaler, for timer and watchdog.
// (RL2) Internal timer modes step prescaler at the internal clock over four.
// (RL3) Input pin counts only with input enable bit 3 set.
// (RL4) Event mode decrements on each falling input edge, edges 333 ns apart.
// (RL5) Gate mode counts at clock over four only while input is high.
// (RL6) Retrigger mode reloads presets on any falling edge while started.
// (RL7) Trigger mode reloads on falling edge only at end of count.
// (RL8) Output pin driven only while output enable bit 0 is high.
// (RL9) At zero, output toggles, or copies level bit when mode bit set.
// (RL10) Clearing watchdog enable bit 6 switches to watchdog, timer disabled.
// (RL11) Watchdog mode stays until the next hardware reset.
// (RL12) Writing 0AAh then 055h to low byte reloads the watchdog counter.
// (RL13) Watchdog reaching zero issues internal chip reset, not on reset pin.
// (RL14) Timer zero raises interrupt onto prioritized or non-maskable channel.
// (RL15) Software should set prescaler and reload before enabling watchdog.
// (RL16) Timer end of count reloads presets and keeps counting, except when trigger mode parks.
module twu_timer_watchdog (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] timer_control_reg,
  input wire logic [1:0] in_mode,
  input wire logic output_level_bit,
  input wire logic timer_function_select,
  input wire logic [7:0] interrupt_vector_reg,
  input wire twu_pkg::twu_preset_t preset,
  input wire logic low_byte_wr,
  input wire logic [7:0] counter_low_byte_reg,
  input wire logic timer_event_input,
  output logic timer_wave_output,
  output logic timer_wave_oe,
  output logic prioritized_irq_channel,
  output logic top_level_irq,
  output logic internal_reset,
  output logic watchdog_active,
  output logic [twu_pkg::TWU_CNT_W-1:0] count_value
);
  import twu_pkg::*;

  twu_state_t s_q;
  twu_state_t s_d;
  logic started;
  logic in_en;
  logic fall;
  logic tick;
  logic step;
  logic zero_hit;
  logic edge_reload;
  logic key_match;
  twu_in_mode_t mode;

  ////////////////////////////////////////////////////////////////////////////
  // Input decode and count step select; writes no state
  always_comb begin
    mode = twu_in_mode_t'(in_mode);
    started = timer_control_reg[TWU_CTRL_START_STOP_BIT_BIT];
    // (RL3) Input enable gate
    in_en = timer_control_reg[TWU_CTRL_INPUT_PIN_ENABLE_BIT] && !s_q.wdog;
    // (RL4) Falling edge detect; source keeps edge spacing
    fall = s_q.in_prev && !timer_event_input;
    // (RL2) Divide-by-four enable
    tick = (s_q.div == TWU_DIV_LAST);
    step = 1'b0;
    // Watchdog ignores the start bit so software cannot halt it
    if (s_q.wdog) begin
      step = tick;
    end else if (started) begin
      if (!in_en) begin
        step = tick;
      end else begin
        case (mode)
          // (RL4) Each falling edge is one count
          TWU_IN_EVENT: begin
            step = fall;
          end
          // (RL5) Count only while input high
          TWU_IN_GATE: begin
            step = tick && timer_event_input;
          end
          // (RL7) Frozen once parked at end
          TWU_IN_TRIG: begin
            step = tick && !s_q.at_end;
          end
          // (RL6) Free run between edges
          TWU_IN_RETRIG: begin
            step = tick;
          end
          default: begin
            step = 1'b0;
          end
        endcase
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Edge reload and key detect
  always_comb begin
    edge_reload = 1'b0;
    key_match = 1'b0;
    if (!s_q.wdog && started && in_en && fall) begin
      // (RL6) Reload on any falling edge
      if (mode == TWU_IN_RETRIG) begin
        edge_reload = 1'b1;
      end
      // (RL7) Reload only once parked at end
      if (mode == TWU_IN_TRIG && s_q.at_end) begin
        edge_reload = 1'b1;
      end
    end
    // (RL12) Second key byte must follow the first directly
    if (low_byte_wr && s_q.key_armed && s_q.wdog) begin
      key_match = (counter_low_byte_reg == TWU_KEY_SECOND);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state; later assignments win, so reloads beat a step
  always_comb begin
    s_d = s_q;
    zero_hit = 1'b0;
    s_d.in_prev = timer_event_input;
    s_d.div = s_q.div + 2'h1;
    s_d.irq_chan = 1'b0;
    s_d.irq_top = 1'b0;
    s_d.wd_reset = 1'b0;
    // (RL10) One-way switch into watchdog
    // (RL11) Never cleared except by reset
    if (!timer_function_select) begin
      s_d.wdog = 1'b1;
    end
    // (RL1) Prescaler then counter
    if (step) begin
      if (s_q.pre != '0) begin
        s_d.pre = s_q.pre - 8'h01;
      end else begin
        s_d.pre = preset.prescale;
        if (s_q.cnt != '0) begin
          s_d.cnt = s_q.cnt - 16'h0001;
        end
        // A count already at zero fires again rather than wrapping
        zero_hit = (s_q.cnt == 16'h0001) || (s_q.cnt == '0);
      end
    end
    if (zero_hit) begin
      if (s_q.wdog) begin
        // (RL13) Internal chip reset pulse only
        s_d.wd_reset = 1'b1;
      end else begin
        // (RL14) Route zero event to selected channel
        s_d.irq_chan = !interrupt_vector_reg[TWU_IVR_CHAN_BIT];
        s_d.irq_top = !interrupt_vector_reg[TWU_IVR_TOP_BIT];
        // (RL9) Toggle or pass software level
        if (timer_control_reg[TWU_CTRL_OUTPUT_MODE_SELECT_BIT]) begin
          s_d.wave = output_level_bit;
        end else begin
          s_d.wave = !s_q.wave;
        end
        if (in_en && mode == TWU_IN_TRIG) begin
          // Trigger mode parks at zero awaiting an edge
          s_d.at_end = 1'b1;
        end else begin
          // (RL16) Auto reload and continue
          s_d.cnt = preset.reload;
          s_d.pre = preset.prescale;
        end
      end
    end
    // (RL6) Edge reload of both presets
    if (edge_reload) begin
      s_d.cnt = preset.reload;
      s_d.pre = preset.prescale;
      s_d.at_end = 1'b0;
    end
    // (RL12) Key pair 0AAh then 055h reloads watchdog
    if (low_byte_wr) begin
      s_d.key_armed = (counter_low_byte_reg == TWU_KEY_FIRST);
    end
    if (key_match) begin
      s_d.cnt = preset.reload;
      s_d.pre = preset.prescale;
    end
    // (RL8) Drive pin only with output enable
    s_d.wave_oe = timer_control_reg[TWU_CTRL_OUTPUT_PIN_ENABLE_BIT] && !s_d.wdog;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Counter starts at full scale; presets are undefined until software acts
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      // Edge memory starts low so a low pin at release is no edge
      s_q <= '{
        div: 2'h0,
        pre: '1,
        cnt: '1,
        wdog: 1'b0,
        key_armed: 1'b0,
        in_prev: 1'b0,
        wave: 1'b0,
        wave_oe: 1'b0,
        irq_chan: 1'b0,
        irq_top: 1'b0,
        wd_reset: 1'b0,
        at_end: 1'b0
      };
    end else begin
      s_q <= s_d;
    end
  end

  assign timer_wave_output = s_q.wave;
  assign timer_wave_oe = s_q.wave_oe;
  assign prioritized_irq_channel = s_q.irq_chan;
  assign top_level_irq = s_q.irq_top;
  assign internal_reset = s_q.wd_reset;
  assign watchdog_active = s_q.wdog;
  assign count_value = s_q.cnt;
endmodule
